// >>> src/dtc_defs.vh
// register offsets, field positions and dividers for the dual timer block
`ifndef DTC_DEFS_VH
`define DTC_DEFS_VH
// ------------------------------------------------------------
// special function register offsets
// ------------------------------------------------------------
`define DTC_ADDR_CTRL   8'h88
`define DTC_ADDR_MODE   8'h89
`define DTC_ADDR_T0LO   8'h8a
`define DTC_ADDR_T1LO   8'h8b
`define DTC_ADDR_T0HI   8'h8c
`define DTC_ADDR_T1HI   8'h8d
`define DTC_ADDR_CKSEL  8'h8e
// ------------------------------------------------------------
// control register fields
// ------------------------------------------------------------
`define DTC_OVF1  7
`define DTC_RUN1  6
`define DTC_OVF0  5
`define DTC_RUN0  4
`define DTC_XFLG1 3
`define DTC_XTYP1 2
`define DTC_XFLG0 1
`define DTC_XTYP0 0
// ------------------------------------------------------------
// mode register fields (per nibble)
// ------------------------------------------------------------
`define DTC_GATE 3
`define DTC_CSEL 2
`define DTC_M13  2'h0
`define DTC_M16  2'h1
`define DTC_M8R  2'h2
`define DTC_M3   2'h3
// ------------------------------------------------------------
// clock select register fields
// ------------------------------------------------------------
`define DTC_CK_RHI  5
`define DTC_CK_RLO  4
`define DTC_CK_SYS1 3
`define DTC_CK_SYS0 2
`define DTC_CK_MASK 8'h3f
`define DTC_RST_VAL 8'h00
// ------------------------------------------------------------
// prescale dividers
// ------------------------------------------------------------
`define DTC_DIV12 8'h0c
`define DTC_DIV4  8'h04
`define DTC_DIV48 8'h30
`define DTC_DIV8  8'h08
`endif

// >>> src/dtc_edge_sync.v
// two-flop synchroniser with falling edge detector for one pin
`timescale 1ns/1ps
module dtc_edge_sync (
    // clock and reset
    input  wire clk,
    input  wire rstn,
    input  wire ce,
    // pin and results
    input  wire pin,
    output reg  level,
    output wire fall
);
    reg meta_r;   // first stage, read only by the second
    reg prev_r;   // previous synchronised sample

    // --------------------------------------------------------
    // synchroniser chain
    // --------------------------------------------------------
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            meta_r <= 1'b1;
            level  <= 1'b1;
            prev_r <= 1'b1;
        end else if (ce) begin
            meta_r <= pin;
            level  <= meta_r;
            prev_r <= level;
        end
    end

    // falling edge from two successive samples
    assign fall = ce & prev_r & ~level;
endmodule

// >>> src/dtc_top.v
// dual counter/timer with control, mode and clock select registers
`timescale 1ns/1ps
`include "dtc_defs.vh"
module dtc_top (
    // clock, reset, enable
    input  wire       clk,
    input  wire       rstn,
    input  wire       ce,
    // special function register bus
    input  wire [7:0] sfr_addr,
    input  wire       sfr_wr,
    input  wire [7:0] sfr_wdata,
    input  wire       sfr_rd,
    output reg  [7:0] sfr_rdata,
    // external pins
    input  wire       count_pin_zero,
    input  wire       count_pin_one,
    input  wire       ext_irq_zero_input,
    input  wire       ext_irq_one_input,
    input  wire       ext_clock,
    // polarity from the external interrupt configuration
    input  wire       ext_irq_zero_polarity,
    input  wire       ext_irq_one_polarity,
    // interrupt controller
    input  wire       ack_timer_zero,
    input  wire       ack_timer_one,
    input  wire       ack_irq_zero,
    input  wire       ack_irq_one,
    output reg        irq_timer_zero,
    output reg        irq_timer_one,
    output reg        irq_ext_zero,
    output reg        irq_ext_one,
    // reload timer clock selects
    output reg        reload_timer_high_clock_select,
    output reg        reload_timer_low_clock_select
);
    // --------------------------------------------------------
    // registers
    // --------------------------------------------------------
    reg  [7:0] ctrl_r;     // timer control register
    reg  [7:0] mode_r;     // timer mode register
    reg  [7:0] cksel_r;    // clock select register
    reg  [7:0] t0lo_r;     // timer zero low byte
    reg  [7:0] t0hi_r;     // timer zero high byte
    reg  [7:0] t1lo_r;     // timer one low byte
    reg  [7:0] t1hi_r;     // timer one high byte
    reg  [5:0] pre_cnt_r;  // prescale divider counter
    reg  [2:0] ext_cnt_r;  // external clock divide-by-8 counter
    reg        i0_prev_r;  // previous active state of irq zero
    reg        i1_prev_r;  // previous active state of irq one

    // --------------------------------------------------------
    // pin synchronisers
    // --------------------------------------------------------
    wire cp0_fall, cp1_fall;
    wire i0_lvl, i1_lvl, xc_fall;

    dtc_edge_sync u_cp0 (.clk(clk), .rstn(rstn), .ce(ce), .pin(count_pin_zero), .level(), .fall(cp0_fall));
    dtc_edge_sync u_cp1 (.clk(clk), .rstn(rstn), .ce(ce), .pin(count_pin_one), .level(), .fall(cp1_fall));
    dtc_edge_sync u_i0 (.clk(clk), .rstn(rstn), .ce(ce), .pin(ext_irq_zero_input), .level(i0_lvl), .fall());
    dtc_edge_sync u_i1 (.clk(clk), .rstn(rstn), .ce(ce), .pin(ext_irq_one_input), .level(i1_lvl), .fall());
    dtc_edge_sync u_xc (.clk(clk), .rstn(rstn), .ce(ce), .pin(ext_clock), .level(), .fall(xc_fall));

    // polarity: 1 means active high
    wire i0_act = ~(i0_lvl ^ ext_irq_zero_polarity);
    wire i1_act = ~(i1_lvl ^ ext_irq_one_polarity);

    // --------------------------------------------------------
    // prescaler
    // --------------------------------------------------------
    reg  [7:0] div_sel;
    reg        pre_tick;
    always @* begin
        case (cksel_r[1:0])
            2'h0:    div_sel = `DTC_DIV12;
            2'h1:    div_sel = `DTC_DIV4;
            2'h2:    div_sel = `DTC_DIV48;
            default: div_sel = `DTC_DIV8;
        endcase
        if (cksel_r[1:0] == 2'h3)
            pre_tick = ce & xc_fall & (ext_cnt_r == 3'h7);
        else
            pre_tick = ce & ({2'h0, pre_cnt_r} == div_sel - 8'h01);
    end

    // prescale counters
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pre_cnt_r <= 6'h00;
            ext_cnt_r <= 3'h0;
        end else if (ce) begin
            if ({2'h0, pre_cnt_r} >= div_sel - 8'h01)
                pre_cnt_r <= 6'h00;
            else
                pre_cnt_r <= pre_cnt_r + 6'h01;
            if (xc_fall)
                ext_cnt_r <= ext_cnt_r + 3'h1;
        end
    end

    // --------------------------------------------------------
    // count enables
    // --------------------------------------------------------
    wire [1:0] m0 = mode_r[1:0];
    wire [1:0] m1 = mode_r[5:4];
    wire       split = (m0 == `DTC_M3);

    wire run0 = ctrl_r[`DTC_RUN0] & (~mode_r[`DTC_GATE] | i0_act);
    wire run1 = ctrl_r[`DTC_RUN1] & (~mode_r[4+`DTC_GATE] | i1_act);

    wire tclk0 = cksel_r[`DTC_CK_SYS0] ? ce : pre_tick;
    wire tclk1 = cksel_r[`DTC_CK_SYS1] ? ce : pre_tick;

    wire inc0 = run0 & (mode_r[`DTC_CSEL] ? cp0_fall : tclk0);
    // timer one pin edges unless split
    wire inc1_src = (mode_r[4+`DTC_CSEL] & ~split) ? cp1_fall : tclk1;
    wire inc1 = (m1 != `DTC_M3) & (split ? 1'b1 : run1) & inc1_src;
    // split high byte runs by timer one run bit
    wire inch = split & ctrl_r[`DTC_RUN1] & tclk0;

    // --------------------------------------------------------
    // next count values with overflow
    // --------------------------------------------------------
    reg [7:0] n0lo, n0hi, n1lo, n1hi;
    reg       ov0, ov1, ovh;
    reg [13:0] s13;
    reg [16:0] s16;
    reg [8:0]  s8;

    // timer zero next value
    always @* begin
        n0lo = t0lo_r;
        n0hi = t0hi_r;
        ov0  = 1'b0;
        ovh  = 1'b0;
        s13  = {1'b0, t0hi_r, t0lo_r[4:0]} + 14'h0001;
        s16  = {1'b0, t0hi_r, t0lo_r} + 17'h00001;
        s8   = {1'b0, t0lo_r} + 9'h001;
        if (inc0) begin
            case (m0)
                `DTC_M13: begin
                    n0lo = {t0lo_r[7:5], s13[4:0]};
                    n0hi = s13[12:5];
                    ov0  = s13[13];
                end
                `DTC_M16: begin
                    n0lo = s16[7:0];
                    n0hi = s16[15:8];
                    ov0  = s16[16];
                end
                `DTC_M8R: begin
                    n0lo = s8[8] ? t0hi_r : s8[7:0];
                    ov0  = s8[8];
                end
                default: begin
                    n0lo = s8[7:0];
                    ov0  = s8[8];
                end
            endcase
        end
        if (inch) begin
            n0hi = t0hi_r + 8'h01;
            ovh  = (t0hi_r == 8'hff);
        end
    end

    reg [13:0] u13;
    reg [16:0] u16;
    reg [8:0]  u8;
    // timer one next value
    always @* begin
        n1lo = t1lo_r;
        n1hi = t1hi_r;
        ov1  = 1'b0;
        u13  = {1'b0, t1hi_r, t1lo_r[4:0]} + 14'h0001;
        u16  = {1'b0, t1hi_r, t1lo_r} + 17'h00001;
        u8   = {1'b0, t1lo_r} + 9'h001;
        if (inc1) begin
            case (m1)
                `DTC_M13: begin
                    n1lo = {t1lo_r[7:5], u13[4:0]};
                    n1hi = u13[12:5];
                    ov1  = u13[13];
                end
                `DTC_M16: begin
                    n1lo = u16[7:0];
                    n1hi = u16[15:8];
                    ov1  = u16[16];
                end
                `DTC_M8R: begin
                    n1lo = u8[8] ? t1hi_r : u8[7:0];
                    ov1  = u8[8];
                end
                default: begin
                    n1lo = t1lo_r;
                end
            endcase
        end
    end

    // in split mode the timer one flag is set by the timer zero high byte overflow, not by timer one
    wire set_ovf1 = split ? ovh : ov1;

    // --------------------------------------------------------
    // register file and flags
    // --------------------------------------------------------
    wire wr_ctrl = ce & sfr_wr & (sfr_addr == `DTC_ADDR_CTRL);
    wire i0_edge = i0_act & ~i0_prev_r;
    wire i1_edge = i1_act & ~i1_prev_r;
    reg  [7:0] ctrl_nxt;

    // control register next value, set wins over clear
    always @* begin
        ctrl_nxt = wr_ctrl ? sfr_wdata : ctrl_r;
        if (ack_timer_one)
            ctrl_nxt[`DTC_OVF1] = 1'b0;
        if (set_ovf1)
            ctrl_nxt[`DTC_OVF1] = 1'b1;
        if (ack_timer_zero)
            ctrl_nxt[`DTC_OVF0] = 1'b0;
        if (ov0)
            ctrl_nxt[`DTC_OVF0] = 1'b1;
        if (ctrl_nxt[`DTC_XTYP1]) begin
            if (ack_irq_one)
                ctrl_nxt[`DTC_XFLG1] = 1'b0;
            if (i1_edge)
                ctrl_nxt[`DTC_XFLG1] = 1'b1;
        end else begin
            ctrl_nxt[`DTC_XFLG1] = i1_act;
        end
        if (ctrl_nxt[`DTC_XTYP0]) begin
            if (ack_irq_zero)
                ctrl_nxt[`DTC_XFLG0] = 1'b0;
            if (i0_edge)
                ctrl_nxt[`DTC_XFLG0] = 1'b1;
        end else begin
            ctrl_nxt[`DTC_XFLG0] = i0_act;
        end
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_r    <= `DTC_RST_VAL;
            mode_r    <= `DTC_RST_VAL;
            cksel_r   <= `DTC_RST_VAL;
            t0lo_r    <= `DTC_RST_VAL;
            t0hi_r    <= `DTC_RST_VAL;
            t1lo_r    <= `DTC_RST_VAL;
            t1hi_r    <= `DTC_RST_VAL;
            i0_prev_r <= 1'b0;
            i1_prev_r <= 1'b0;
        end else if (ce) begin
            ctrl_r    <= ctrl_nxt;
            i0_prev_r <= i0_act;
            i1_prev_r <= i1_act;
            t0lo_r    <= n0lo;
            t0hi_r    <= n0hi;
            t1lo_r    <= n1lo;
            t1hi_r    <= n1hi;
            if (sfr_wr) begin
                case (sfr_addr)
                    `DTC_ADDR_MODE:  mode_r <= sfr_wdata;
                    `DTC_ADDR_CKSEL: cksel_r <= sfr_wdata & `DTC_CK_MASK;
                    `DTC_ADDR_T0LO:  t0lo_r <= sfr_wdata;
                    `DTC_ADDR_T0HI:  t0hi_r <= sfr_wdata;
                    `DTC_ADDR_T1LO:  t1lo_r <= sfr_wdata;
                    `DTC_ADDR_T1HI:  t1hi_r <= sfr_wdata;
                    default: ;
                endcase
            end
        end
    end

    // --------------------------------------------------------
    // read data and outputs
    // --------------------------------------------------------
    reg [7:0] rd_mux;
    // read multiplexer, unmapped reads zero
    always @* begin
        case (sfr_addr)
            `DTC_ADDR_CTRL:  rd_mux = ctrl_r;
            `DTC_ADDR_MODE:  rd_mux = mode_r;
            `DTC_ADDR_CKSEL: rd_mux = cksel_r;
            `DTC_ADDR_T0LO:  rd_mux = t0lo_r;
            `DTC_ADDR_T0HI:  rd_mux = t0hi_r;
            `DTC_ADDR_T1LO:  rd_mux = t1lo_r;
            `DTC_ADDR_T1HI:  rd_mux = t1hi_r;
            default:         rd_mux = 8'h00;
        endcase
    end

    // registered outputs
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sfr_rdata                      <= 8'h00;
            irq_timer_zero                 <= 1'b0;
            irq_timer_one                  <= 1'b0;
            irq_ext_zero                   <= 1'b0;
            irq_ext_one                    <= 1'b0;
            reload_timer_high_clock_select <= 1'b0;
            reload_timer_low_clock_select  <= 1'b0;
        end else if (ce) begin
            if (sfr_rd)
                sfr_rdata <= rd_mux;
            irq_timer_zero <= ctrl_nxt[`DTC_OVF0];
            irq_timer_one  <= ctrl_nxt[`DTC_OVF1];
            irq_ext_zero   <= ctrl_nxt[`DTC_XFLG0];
            irq_ext_one    <= ctrl_nxt[`DTC_XFLG1];
            reload_timer_high_clock_select <= cksel_r[`DTC_CK_RHI];
            reload_timer_low_clock_select  <= cksel_r[`DTC_CK_RLO];
        end
    end
endmodule

// >>> test/dtc_checker.sv
// concurrent checks on the dual timer top ports
`timescale 1ns/1ps
module dtc_checker (
    // clock and reset
    input wire       clk,
    input wire       rstn,
    input wire       ce,
    // register bus
    input wire [7:0] sfr_addr,
    input wire       sfr_wr,
    input wire [7:0] sfr_wdata,
    input wire       sfr_rd,
    input wire [7:0] sfr_rdata,
    // flags and clock selects
    input wire       irq_timer_zero,
    input wire       irq_timer_one,
    input wire       irq_ext_zero,
    input wire       irq_ext_one,
    input wire       reload_timer_high_clock_select,
    input wire       reload_timer_low_clock_select
);
    // ------------------------------------------------------------
    // helper terms
    // ------------------------------------------------------------
    wire       rd_ok = ce && sfr_rd;                          // read taken
    wire       ck_wr = ce && sfr_wr && (sfr_addr == 8'h8e);   // clock select write
    wire [1:0] sel   = {reload_timer_high_clock_select, reload_timer_low_clock_select};
    wire [3:0] irqs  = {irq_timer_zero, irq_timer_one, irq_ext_zero, irq_ext_one};
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    hold_rdata_a: assert property (!rd_ok |=> $stable(sfr_rdata))
        else $error("read data moved without a read");
    rsv_zero_a: assert property (rd_ok && sfr_addr == 8'h8e |=> sfr_rdata[7:6] == 2'h0)
        else $error("reserved clock select bits read non zero");
    unmapped_a: assert property (rd_ok && (sfr_addr < 8'h88 || sfr_addr > 8'h8e) |=> sfr_rdata == 8'h00)
        else $error("unmapped read not zero");
    mode_back_a: assert property (ce && sfr_wr && sfr_addr == 8'h89 ##1 rd_ok && !sfr_wr && sfr_addr == 8'h89
        |=> sfr_rdata == $past(sfr_wdata, 2)) else $error("mode register readback wrong");
    cksel_back_a: assert property (ck_wr ##1 rd_ok && !sfr_wr && sfr_addr == 8'h8e
        |=> sfr_rdata == ($past(sfr_wdata, 2) & 8'h3f)) else $error("clock select readback wrong");
    sel_follow_a: assert property (ck_wr ##1 !ck_wr [*2] |-> sel == $past(sfr_wdata[5:4], 2))
        else $error("reload clock selects do not follow register");
    sel_still_a: assert property (!ck_wr [*2] |=> $stable(sel))
        else $error("reload clock selects moved without a write");
    freeze_a: assert property (!ce |=> $stable(irqs) && $stable(sel) && $stable(sfr_rdata))
        else $error("outputs moved while disabled");
endmodule

// >>> test/dtc_intc_model.sv
// interrupt controller model that acknowledges pending requests
`timescale 1ns/1ps
module dtc_intc_model (
    // clock and reset
    input  wire       clk,
    input  wire       rstn,
    // behaviour controls
    input  wire       en,
    input  wire       slow,
    // requests and acknowledges
    input  wire [3:0] irq,
    output reg  [3:0] ack
);
    reg [1:0] dly_r;   // wait count in slow mode
    // vector acknowledge pulse
    // one pulse for the lowest pending request, never two in a row
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ack   <= 4'h0;
            dly_r <= 2'h0;
        end else begin
            ack <= 4'h0;
            if (en && (irq != 4'h0) && (ack == 4'h0)) begin
                if (slow && (dly_r != 2'h3)) begin
                    dly_r <= dly_r + 2'h1;
                end else begin
                    ack   <= irq & (~irq + 4'h1);
                    dly_r <= 2'h0;
                end
            end
        end
    end
endmodule

// >>> test/tb.sv
// self-checking bench for the dual timer block
`timescale 1ns/1ps
module tb;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    reg        clk, rstn, ce, sfr_wr, sfr_rd, cp0, cp1, ei0, ei1, xclk, en, slow, pl0, pl1;
    reg  [7:0] sfr_addr, sfr_wdata, d, r;
    wire [7:0] sfr_rdata;
    wire [3:0] irqv, ackv;
    wire       hi_sel, lo_sel;
    int        n_fail = 0, total_checks = 0, cyc = 0, n, k;
    dtc_top dut_u (.clk(clk), .rstn(rstn), .ce(ce), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .count_pin_zero(cp0),
        .count_pin_one(cp1), .ext_irq_zero_input(ei0), .ext_irq_one_input(ei1), .ext_clock(xclk),
        .ext_irq_zero_polarity(pl0), .ext_irq_one_polarity(pl1), .ack_timer_zero(ackv[0]),
        .ack_timer_one(ackv[1]), .ack_irq_zero(ackv[2]), .ack_irq_one(ackv[3]),
        .irq_timer_zero(irqv[0]), .irq_timer_one(irqv[1]), .irq_ext_zero(irqv[2]), .irq_ext_one(irqv[3]),
        .reload_timer_high_clock_select(hi_sel), .reload_timer_low_clock_select(lo_sel));
    dtc_intc_model intc_u (.clk(clk), .rstn(rstn), .en(en), .slow(slow), .irq(irqv), .ack(ackv));
    // ------------------------------------------------------------
    // clocks and timeout
    // ------------------------------------------------------------
    initial begin clk = 0; forever #12.5 clk = ~clk; end
    initial begin xclk = 0; forever begin repeat (2) @(negedge clk); xclk = ~xclk; end end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin n_fail++; test_done(); end
    end
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task test_done;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task chk(input [7:0] got, input [7:0] exp);
        total_checks++;
        if (got !== exp) begin n_fail++; $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); end
    endtask
    task wr(input [7:0] ad, input [7:0] dv);
        @(negedge clk); sfr_addr = ad; sfr_wdata = dv; sfr_wr = 1;
        @(negedge clk); sfr_wr = 0;
    endtask
    task rd(input [7:0] ad, output [7:0] dv);
        @(negedge clk); sfr_addr = ad; sfr_rd = 1;
        @(negedge clk); sfr_rd = 0; dv = sfr_rdata;
    endtask
    task rdc(input [7:0] ad, input [7:0] ex);
        reg [7:0] v;
        rd(ad, v);
        chk(v, ex);
    endtask
    // write then read back at the very next edge
    task wrrd(input [7:0] ad, input [7:0] dv, input [7:0] ex);
        @(negedge clk); sfr_addr = ad; sfr_wdata = dv; sfr_wr = 1;
        @(negedge clk); sfr_wr = 0; sfr_rd = 1;
        @(negedge clk); sfr_rd = 0;
        chk(sfr_rdata, ex);
    endtask
    // stop, load mode, clock select and counts of timer b, then start
    task setup(input [7:0] md, input [7:0] ck, input [7:0] tl, input [7:0] th, input [7:0] run, input int b);
        wr(8'h88, 8'h00); wr(8'h89, md); wr(8'h8e, ck);
        wr(8'h8a + b[7:0], tl); wr(8'h8c + b[7:0], th); wr(8'h88, run);
    endtask
    // cycles until the next rise of a request, bounded
    task rise(input int b, output int cnt);
        cnt = 0;
        while (irqv[b] !== 1'b0 && cnt < 5000) begin @(negedge clk); cnt++; end
        while (irqv[b] !== 1'b1 && cnt < 5000) begin @(negedge clk); cnt++; end
    endtask
    // overflow period for a reload of 0xfc, four ticks
    function [7:0] exp_per(input [1:0] sca, input sys);
        exp_per = sys ? 8'h04 : (sca == 2'h0) ? 8'h30 : (sca == 2'h1) ? 8'h10 : (sca == 2'h2) ? 8'hc0 : 8'h80;
    endfunction
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        rstn = 0; ce = 1; sfr_wr = 0; sfr_rd = 0; sfr_addr = 8'h00; sfr_wdata = 8'h00;
        cp0 = 1; cp1 = 1; ei0 = 1; ei1 = 1; en = 0; slow = 0; pl0 = 0; pl1 = 0;
        r = 8'($urandom(32'h595b));
        repeat (2) @(negedge clk);
        rstn = 1;
        for (k = 0; k < 8; k++) rdc(8'h88 + k[7:0], 8'h00);
        ce = 0;
        wr(8'h8e, 8'hff);
        ce = 1;
        rdc(8'h8e, 8'h00);
        wrrd(8'h8e, 8'hff, 8'h3f);
        repeat (2) @(negedge clk);
        chk({6'h0, hi_sel, lo_sel}, 8'h03);
        wrrd(8'h8e, 8'h10, 8'h10);
        repeat (2) @(negedge clk);
        chk({6'h0, hi_sel, lo_sel}, 8'h01);
        wr(8'h89, 8'h00);
        for (k = 0; k < 12; k++) begin
            sfr_addr = 8'h89 + 8'($urandom_range(5));
            d = 8'($urandom);
            if (sfr_addr == 8'h89) d = d & 8'hfe;
            wrrd(sfr_addr, d, (sfr_addr == 8'h8e) ? (d & 8'h3f) : d);
        end
        $display("test registers done");
        en = 1;
        for (k = 0; k < 10; k++) begin
            setup(8'h22, (k[3]) ? (k[0] ? 8'h08 : 8'h04) : {6'h0, k[2:1]}, 8'hfc, 8'hfc, k[0] ? 8'h40 : 8'h10, k[0]);
            rise(k[0], n);
            rise(k[0], n);
            chk(n[7:0], exp_per(k[2:1], k[3]));
        end
        $display("test clock sources done");
        en = 0;
        for (k = 0; k < 3; k++) begin
            r = 8'($urandom);
            setup(k[7:0], 8'h02, (k == 0) ? 8'h1f : 8'hff, (k == 2) ? r : 8'hff, 8'h10, 0);
            rise(0, n);
            wr(8'h88, 8'h00);
            rd(8'h8a, d);
            chk(d & ((k == 0) ? 8'h1f : 8'hff), (k == 2) ? r : 8'h00);
            rdc(8'h8c, (k == 2) ? r : 8'h00);
        end
        setup(8'h03, 8'h0c, 8'h33, 8'hfe, 8'h40, 0);
        repeat (6) @(negedge clk);
        chk({6'h0, irqv[1:0]}, 8'h02);
        rdc(8'h8a, 8'h33);
        $display("test modes done");
        setup(8'h55, 8'h0c, 8'hfd, 8'hff, 8'h00, 1);
        setup(8'h55, 8'h0c, 8'hfd, 8'hff, 8'h50, 0);
        for (k = 0; k < 3; k++) begin
            if (k == 2) rdc(8'h8b, 8'hff);
            cp0 = 0; cp1 = 0; repeat (3) @(negedge clk);
            cp0 = 1; cp1 = 1; repeat (3) @(negedge clk);
        end
        repeat (2) @(negedge clk);
        rdc(8'h8a, 8'h00);
        chk({6'h0, irqv[1:0]}, 8'h03);
        setup(8'h90, 8'h08, 8'h00, 8'h00, 8'h40, 1);
        repeat (8) @(negedge clk);
        rdc(8'h8b, 8'h00);
        ei1 = 0; repeat (20) @(negedge clk);
        ei1 = 1; repeat (6) @(negedge clk);
        rd(8'h8b, d);
        repeat (8) @(negedge clk);
        rdc(8'h8b, d);
        chk({7'h0, d > 8'h0f}, 8'h01);
        wr(8'h89, 8'h30);
        rd(8'h8b, d);
        repeat (8) @(negedge clk);
        rdc(8'h8b, d);
        $display("test counting done");
        slow = 1;
        for (k = 0; k < 4; k++) begin
            wr(8'h88, k[1] ? 8'h05 : 8'h00);
            if (k[0]) ei1 = 0; else ei0 = 0;
            repeat (5) @(negedge clk);
            chk({7'h0, irqv[2 + k[0]]}, 8'h01);
            ei0 = 1; ei1 = 1; repeat (5) @(negedge clk);
            chk({7'h0, irqv[2 + k[0]]}, {7'h0, k[1]});
            en = 1; repeat (10) @(negedge clk);
            en = 0;
            chk({7'h0, irqv[2 + k[0]]}, 8'h00);
        end
        // idle high pins become active once polarity says active high
        wr(8'h88, 8'h00);
        pl0 = 1; pl1 = 1; repeat (3) @(negedge clk);
        chk({6'h0, irqv[3:2]}, 8'h03);
        pl0 = 0; pl1 = 0; repeat (3) @(negedge clk);
        chk({6'h0, irqv[3:2]}, 8'h00);
        $display("test external requests done");
        test_done();
    end
endmodule
bind dtc_top dtc_checker chk_u (.clk, .rstn, .ce, .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_rd, .sfr_rdata,
    .irq_timer_zero, .irq_timer_one, .irq_ext_zero, .irq_ext_one,
    .reload_timer_high_clock_select, .reload_timer_low_clock_select);
